// *** include/eeprom_cmd_pkg.sv ***
// constants, state codes and carrier types of the three-wire eeprom command block
// assumes a 50 MHz system clock and a 64 x 16 bit storage array

package eeprom_cmd_pkg;

  // array shape and frame field widths
  localparam int WORDS = 64;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int OPCODE_BITS = 2;
  localparam int WORD_ADDR_BITS = 6;
  localparam int BYTE_ADDR_BITS = 7;
  localparam int BYTE_SEL_BITS = 1;
  localparam int HEADER_BITS = OPCODE_BITS + BYTE_ADDR_BITS;
  localparam int SUB_SHIFT_BYTE = BYTE_ADDR_BITS - OPCODE_BITS;
  localparam int SUB_SHIFT_WORD = WORD_ADDR_BITS - OPCODE_BITS;

  // opcodes and sub-commands of opcode 00
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;

  // bit counter end points, counted from zero
  localparam logic [4:0] BIT_COUNT_ZERO = 5'h00;
  localparam logic [4:0] BIT_COUNT_STEP = 5'h01;
  localparam logic [4:0] HEAD_LAST_BYTE = 5'(HEADER_BITS - 1);
  localparam logic [4:0] HEAD_LAST_WORD = 5'(OPCODE_BITS + WORD_ADDR_BITS - 1);
  localparam logic [4:0] DATA_LAST_BYTE = 5'(BYTE_BITS - 1);
  localparam logic [4:0] DATA_LAST_WORD = 5'(WORD_BITS - 1);

  // stored values
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // self-timed program cycle
  localparam int CLOCK_HZ = 50_000_000;
  localparam int MS_PER_SECOND = 1000;
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int PROGRAM_CYCLE_CYCLES = PROGRAM_CYCLE_TIME_MS * (CLOCK_HZ / MS_PER_SECOND);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HEAD = 3'h1,
    ST_DATA = 3'h3,
    ST_DONE = 3'h2,
    ST_READ = 3'h6
  } frame_state_type;

  // raw header as shifted in, in each organization
  typedef struct packed {
    logic [1:0] opcode;
    logic [6:0] addr;
  } byte_frame_type;

  typedef struct packed {
    logic pad;
    logic [1:0] opcode;
    logic [5:0] addr;
  } word_frame_type;

  // header after decoding, organization-neutral
  typedef struct packed {
    logic [1:0] opcode;
    logic [1:0] sub;
    logic [5:0] index;
    logic byte_sel;
  } header_type;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } word_bytes_type;

endpackage

// *** rtl/bit_sync.sv ***
// two-flop level synchroniser, one per bit of a group
// assumes each bit is a slow level or a toggle; bits of a group may land one edge apart

`timescale 1ns/1ps

module bit_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // levels
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage;

  // first stage is read only by the second
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stage <= {WIDTH{1'b0}};
      o_level <= {WIDTH{1'b0}};
    end else begin
      stage <= i_level;
      o_level <= stage;
    end
  end

endmodule

// *** rtl/eeprom_command_interface.sv ***
// command decoder, storage array and serial read path of a three-wire serial eeprom
// assumes the host drives select and data-in relative to the serial clock, which
// may stop between frames; the system clock runs free and times the program cycle
//
// Operation
// R1 - frame opens with select high, start one
// R2 - opcode 10 reads seven or six bit address
// R3 - opcode 00 address 11 enables programming
// R4 - opcode 11 erases the addressed location
// R5 - opcode 01 writes address then data
// R6 - 00 with 10 erases all, high supply
// R7 - 00 with 01 writes data everywhere
// R8 - 00 with 00 disables programming afterwards
// R9 - host sends every don't-care address bit
// R10 - read data leaves serially after decoding
// R11 - read output changes on serial clock rise
// R12 - zero dummy bit, then data MSB first
// R13 - ignore commands in reset, then standby
// R14 - host waits 100 us after power
// R15 - fixed variant always uses sixteen bit words
// R16 - programming disabled at power up
// R17 - erase sets location to all ones
// R18 - select high shows busy zero, ready one
// R19 - reads work whether enabled or not
// R20 - program cycle ends within five ms
// R21 - sample on clock rise, select low aborts

`timescale 1ns/1ps

module eeprom_command_interface
  import eeprom_cmd_pkg::*;
#(
  parameter int PROGRAM_CYCLES = PROGRAM_CYCLE_CYCLES,
  parameter bit FIXED_WORD_ORG = 1'b0
) (
  // system clock and power-on reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // serial link from the host
  input wire logic i_serial_clock_in,
  input wire logic i_select,
  input wire logic i_serial_data_in,
  // straps
  input wire logic i_word_size_select,
  input wire logic i_high_supply,
  // serial data out, two signals of a tristate pin
  output logic o_serial_data_out,
  output logic o_serial_data_out_enable_n
);

  localparam int TIMER_BITS = $clog2(PROGRAM_CYCLES + 1);

  function automatic header_type decode_header(input logic [8:0] raw, input logic word);
    byte_frame_type b;
    word_frame_type w;
    header_type h;
    b = raw;
    w = raw;
    h.opcode = word ? w.opcode : b.opcode;
    h.sub = word ? 2'(w.addr >> SUB_SHIFT_WORD) : 2'(b.addr >> SUB_SHIFT_BYTE);
    h.index = word ? w.addr : 6'(b.addr >> BYTE_SEL_BITS);
    h.byte_sel = word ? 1'b0 : 1'(b.addr);
    return h;
  endfunction

  // places the low byte of data into one half of old, or replaces the whole word
  function automatic logic [15:0] merge_word(input logic [15:0] old, input logic [15:0] data,
                                             input logic word, input logic byte_sel);
    word_bytes_type o;
    word_bytes_type d;
    o = old;
    d = data;
    if (!word && byte_sel) begin
      o.high = d.low;
    end else if (!word) begin
      o.low = d.low;
    end else begin
      o = d;
    end
    return o;
  endfunction

  // serial clock domain
  frame_state_type state;
  frame_state_type next_state;
  logic [4:0] bit_count;
  logic [4:0] next_bit_count;
  logic [8:0] hdr;
  logic [15:0] data;
  logic [15:0] rd_shift;
  logic in_frame;
  logic rd_active;
  logic rd_bit;
  logic prog_enabled;
  logic start_toggle;
  logic [15:0] mem [WORDS];
  logic busy_sk;
  logic org_sk;
  logic supply_sk;

  // system clock domain
  logic cs_s;
  logic frame_s;
  logic rd_s;
  logic bit_s;
  logic start_s;
  logic start_seen;
  logic busy;
  logic armed;
  logic [TIMER_BITS-1:0] timer;

  // R21 - select low drops any partial frame
  wire frame_rst_n = i_resetn & i_select;

  bit_sync #(
    .WIDTH(3)
  ) sk_sync (
    .i_clock(i_serial_clock_in),
    .i_resetn(i_resetn),
    .i_level({busy, i_word_size_select, i_high_supply}),
    .o_level({busy_sk, org_sk, supply_sk})
  );

  // R15 - fixed variant forces word organization
  wire word_mode = FIXED_WORD_ORG | org_sk;

  wire [8:0] hdr_next = {hdr[7:0], i_serial_data_in};
  wire [15:0] data_next = {data[14:0], i_serial_data_in};
  wire [4:0] head_last_count = word_mode ? HEAD_LAST_WORD : HEAD_LAST_BYTE;
  wire [4:0] data_last_count = word_mode ? DATA_LAST_WORD : DATA_LAST_BYTE;
  wire head_last = (state == ST_HEAD) && (bit_count == head_last_count);
  wire data_last = (state == ST_DATA) && (bit_count == data_last_count);

  // R9 - decode waits for the full-length address field
  header_type cur;
  assign cur = decode_header((state == ST_HEAD) ? hdr_next : hdr, word_mode);

  wire op_special = cur.opcode == OP_SPECIAL;
  // R2 - read opcode
  wire enter_read = head_last && (cur.opcode == OP_READ);
  // R3 - enable command
  wire enable_cmd = head_last && op_special && (cur.sub == SUB_ENABLE);
  // R8 - disable command
  wire disable_cmd = head_last && op_special && (cur.sub == SUB_DISABLE);
  // R4 - single erase
  wire erase_req = head_last && (cur.opcode == OP_ERASE);
  // R6 - erase all only on the high supply range
  wire erase_all_req = head_last && op_special && (cur.sub == SUB_ERASE_ALL) && supply_sk;
  // R5 R7 - write and write-all collect a data field
  wire enter_data = head_last &&
                    ((cur.opcode == OP_WRITE) || (op_special && (cur.sub == SUB_WRITE_ALL)));
  wire commit_req = erase_req || erase_all_req || data_last;
  // R16 - nothing is programmed unless enabled, nor while a cycle runs
  wire commit = commit_req && prog_enabled && !busy_sk;
  wire commit_all = op_special;
  wire erase_kind = (cur.opcode == OP_ERASE) || (op_special && (cur.sub == SUB_ERASE_ALL));
  wire erase_commit = commit && (cur.opcode == OP_ERASE);
  wire [5:0] commit_index = cur.index;

  word_bytes_type data_bytes;
  assign data_bytes = data_next;
  wire [15:0] data_word = word_mode ? data_next : {data_bytes.low, data_bytes.low};
  // R17 - erased cells read as ones
  wire [15:0] commit_value = erase_kind ? ERASED_WORD : data_word;
  wire [15:0] single_value = merge_word(mem[commit_index], commit_value, word_mode, cur.byte_sel);

  word_bytes_type stored;
  assign stored = mem[cur.index];
  wire [7:0] stored_byte = cur.byte_sel ? stored.high : stored.low;
  wire [15:0] read_word = word_mode ? mem[cur.index] : {stored_byte, BYTE_ZERO};
  wire read_msb = read_word[WORD_BITS-1];

  // R12 - dummy zero first, then data from the top bit
  wire next_rd_bit = enter_read ? 1'b0 : (state == ST_READ) ? rd_shift[WORD_BITS-1] : rd_bit;
  wire [15:0] next_rd_shift = enter_read ? read_word :
                              (state == ST_READ) ? {rd_shift[WORD_BITS-2:0], 1'b0} : rd_shift;

  // R1 - a one after select rises is the start marker
  always_comb begin
    next_state = state;
    next_bit_count = 5'(bit_count + BIT_COUNT_STEP);
    unique case (state)
      ST_IDLE: begin
        next_bit_count = BIT_COUNT_ZERO;
        if (i_serial_data_in) begin
          next_state = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (head_last) begin
          next_bit_count = BIT_COUNT_ZERO;
          if (enter_read) begin
            next_state = ST_READ;
          end else if (enter_data) begin
            next_state = ST_DATA;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DATA: begin
        if (data_last) begin
          next_state = ST_DONE;
        end
      end
      ST_READ, ST_DONE: begin
        next_bit_count = bit_count;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // R21 - data-in sampled on the rising serial clock
  always_ff @(posedge i_serial_clock_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state <= ST_IDLE;
      bit_count <= BIT_COUNT_ZERO;
      in_frame <= 1'b0;
    end else begin
      state <= next_state;
      bit_count <= next_bit_count;
      in_frame <= next_state != ST_IDLE;
    end
  end

  always_ff @(posedge i_serial_clock_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      hdr <= {HEADER_BITS{1'b0}};
      data <= {WORD_BITS{1'b0}};
    end else begin
      hdr <= (state == ST_HEAD) ? hdr_next : hdr;
      data <= (state == ST_DATA) ? data_next : data;
    end
  end

  // R10 R11 - read bits move only on the rising serial clock
  always_ff @(posedge i_serial_clock_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rd_shift <= {WORD_BITS{1'b0}};
      rd_bit <= 1'b0;
      rd_active <= 1'b0;
    end else begin
      rd_shift <= next_rd_shift;
      rd_bit <= next_rd_bit;
      rd_active <= next_state == ST_READ;
    end
  end

  // R13 R16 - reset leaves programming disabled and the link idle
  always_ff @(posedge i_serial_clock_in or negedge i_resetn) begin
    if (!i_resetn) begin
      prog_enabled <= 1'b0;
      start_toggle <= 1'b0;
    end else begin
      prog_enabled <= enable_cmd | (prog_enabled & ~disable_cmd);
      start_toggle <= start_toggle ^ commit;
    end
  end

  // R4 R5 R6 R7 - erases written at the decoding edge, writes at the last data bit, status covers the cycle
  always_ff @(posedge i_serial_clock_in) begin
    for (int i = 0; i < WORDS; i++) begin
      if (commit && commit_all) begin
        mem[i] <= commit_value;
      end else if (commit && (6'(i) == commit_index)) begin
        mem[i] <= single_value;
      end
    end
  end

  bit_sync #(
    .WIDTH(5)
  ) ck_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_level({i_select, in_frame, rd_active, rd_bit, start_toggle}),
    .o_level({cs_s, frame_s, rd_s, bit_s, start_s})
  );

  wire start_evt = start_s ^ start_seen;
  wire timer_last = timer == TIMER_BITS'(PROGRAM_CYCLES - 1);
  // R20 - busy lasts exactly the program cycle count
  wire next_busy = start_evt | (busy & ~timer_last);
  wire [TIMER_BITS-1:0] next_timer = start_evt ? {TIMER_BITS{1'b0}} :
                                     busy ? TIMER_BITS'(timer + 1'b1) : timer;
  // status is offered only if select rises before the cycle ends
  wire next_armed = start_evt | (armed & (busy | cs_s));
  // R18 - zero while busy, one once ready
  wire next_out = rd_s ? bit_s : ~busy;
  wire next_out_en_n = ~(cs_s & (rd_s | (armed & ~frame_s)));

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      start_seen <= 1'b0;
      busy <= 1'b0;
      timer <= {TIMER_BITS{1'b0}};
      armed <= 1'b0;
    end else begin
      start_seen <= start_s;
      busy <= next_busy;
      timer <= next_timer;
      armed <= next_armed;
    end
  end

  // the pin lags the serial edge by the two-flop crossing plus this flop
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_data_out <= 1'b0;
      o_serial_data_out_enable_n <= 1'b1;
    end else begin
      o_serial_data_out <= next_out;
      o_serial_data_out_enable_n <= next_out_en_n;
    end
  end

  a_frame_start: assert property ( // R1
    @(posedge i_serial_clock_in) disable iff (!frame_rst_n)
    (state == ST_IDLE && i_serial_data_in) |=> (state == ST_HEAD && in_frame))
    else $error("start marker did not open a header");

  a_read_dummy_bit: assert property ( // R12
    @(posedge i_serial_clock_in) disable iff (!frame_rst_n)
    enter_read |=> (rd_active && !rd_bit))
    else $error("read did not begin with a zero dummy bit");

  a_read_msb_first: assert property ( // R12
    @(posedge i_serial_clock_in) disable iff (!frame_rst_n)
    enter_read |=> ##1 (rd_bit == $past(read_msb, 2)))
    else $error("first data bit is not the top stored bit");

  a_read_when_disabled: assert property ( // R19
    @(posedge i_serial_clock_in) disable iff (!frame_rst_n)
    (head_last && cur.opcode == OP_READ && !prog_enabled) |=> (state == ST_READ))
    else $error("read refused while programming disabled");

  a_enable_cmd: assert property ( // R3
    @(posedge i_serial_clock_in) disable iff (!frame_rst_n)
    enable_cmd |=> prog_enabled)
    else $error("enable command left programming disabled");

  a_disable_cmd: assert property ( // R8
    @(posedge i_serial_clock_in) disable iff (!frame_rst_n)
    disable_cmd |=> (!prog_enabled && start_toggle == $past(start_toggle)))
    else $error("disable command left programming enabled");

  a_program_gated: assert property ( // R16
    @(posedge i_serial_clock_in) disable iff (!i_resetn)
    (start_toggle != $past(start_toggle)) |-> $past(prog_enabled))
    else $error("programming started while disabled");

  // the host drops select right after an erase, so this waits for the next frame's edge
  a_erase_ones: assert property ( // R17
    @(posedge i_serial_clock_in) disable iff (!i_resetn)
    (erase_commit && word_mode) |=> (mem[$past(commit_index)] == ERASED_WORD))
    else $error("erased word is not all ones");

  a_cycle_start: assert property ( // R20
    @(posedge i_clock) disable iff (!i_resetn)
    start_evt |=> (busy && timer == {TIMER_BITS{1'b0}}))
    else $error("program cycle did not start busy");

  a_cycle_bound: assert property ( // R20
    @(posedge i_clock) disable iff (!i_resetn)
    busy |-> (timer < PROGRAM_CYCLES))
    else $error("program cycle overran its time");

  a_status_busy: assert property ( // R18
    @(posedge i_clock) disable iff (!i_resetn)
    (cs_s && armed && busy && !frame_s && !rd_s) |=>
      (!o_serial_data_out_enable_n && !o_serial_data_out))
    else $error("busy status not shown as zero");

endmodule

// *** tb/eeprom_host_model.sv ***
// host side of the three-wire link: frames instructions and samples data out
// assumes the device answers data out within 80 ns of a serial clock rise

`timescale 1ns/1ps

module eeprom_host_model
  import eeprom_cmd_pkg::*;
(
  // link lines toward the device
  output logic o_serial_clock,
  output logic o_select,
  output logic o_data,
  // answer from the device
  input wire logic i_data_out,
  input wire logic i_data_out_enable_n
);
  localparam time HALF = 15ns;
  // read bits are stretched so the device's crossing lag has settled
  localparam time SETTLE = 90ns;

  initial begin
    o_serial_clock = 1'b0;
    o_select = 1'b0;
    o_data = 1'b1;
  end

  // nothing holds a released pin, so a stale level is shown inverted to catch a late enable
  function automatic logic pin();
    return i_data_out_enable_n ? ~i_data_out : i_data_out;
  endfunction

  // clock stands still outside frames, except these pulses with select low
  task automatic idle(input int n);
    repeat (n) begin
      #HALF o_serial_clock = 1'b1;
      #HALF o_serial_clock = 1'b0;
    end
  endtask

  task automatic shift(input logic [40:0] bits, input int n, input int rd_n,
                       output logic [16:0] rd);
    rd = '0;
    o_select = 1'b1;
    for (int k = n - 1; k >= 0; k--) begin
      o_data = bits[k];
      #HALF o_serial_clock = 1'b1;
      if (k == 0 && rd_n > 0) begin
        #SETTLE rd = {rd[15:0], pin()};
      end else begin
        #HALF;
      end
      o_serial_clock = 1'b0;
    end
    for (int k = 1; k < rd_n; k++) begin
      o_data = ~o_data;
      #HALF o_serial_clock = 1'b1;
      #SETTLE rd = {rd[15:0], pin()};
      o_serial_clock = 1'b0;
    end
    #HALF o_select = 1'b0;
    o_data = ~o_data;
    #100ns;
  endtask

  // hold select until ready
  // status is lost if the cycle ends while select is low, so select stays high here
  task automatic status(input int n, output logic s, output logic en_n);
    s = 1'b0;
    en_n = 1'b1;
    o_select = 1'b1;
    for (int k = 0; k <= n && s !== 1'b1; k++) begin
      #100ns s = pin();
      en_n = i_data_out_enable_n;
    end
    o_select = 1'b0;
    o_data = ~o_data;
    #100ns;
  endtask
endmodule

// *** tb/three_wire_eeprom_command_interface_tb.sv ***
// self-checking bench of the eeprom command block, host model on the link
// assumes a 50 MHz system clock and a shortened program cycle

`timescale 1ns/1ps

`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module three_wire_eeprom_command_interface_tb;
  import eeprom_cmd_pkg::*;
  localparam int CYCLES = 50;
  logic i_clock, i_resetn, i_word_size_select, i_high_supply;
  logic sck, sel, sdi, o_serial_data_out, o_serial_data_out_enable_n;
  int fails = 0, comparisons = 0;
  logic word;
  logic [15:0] w, d, b;
  logic [6:0] a1, a2;
  logic [16:0] rd;
  logic s, en_n;

  eeprom_command_interface #(.PROGRAM_CYCLES(CYCLES), .FIXED_WORD_ORG(1'b0))
  eeprom_command_interface_i (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_serial_clock_in(sck),
    .i_select(sel), .i_serial_data_in(sdi), .i_word_size_select(i_word_size_select),
    .i_high_supply(i_high_supply), .o_serial_data_out(o_serial_data_out),
    .o_serial_data_out_enable_n(o_serial_data_out_enable_n));

  eeprom_host_model eeprom_host_model_i (
    .o_serial_clock(sck), .o_select(sel), .o_data(sdi),
    .i_data_out(o_serial_data_out), .i_data_out_enable_n(o_serial_data_out_enable_n));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  function automatic logic [40:0] frame(input logic [1:0] op, input logic [6:0] a,
                                        input logic [15:0] dv, input int dn);
    logic [40:0] f;
    f = word ? 41'({1'b1, op, a[5:0]}) : 41'({1'b1, op, a});
    return (f << dn) | (41'(dv) & ((41'h1 << dn) - 41'h1));
  endfunction

  // special commands carry their sub-code in the top address bits
  function automatic logic [6:0] sub_addr(input logic [1:0] sub);
    return word ? {1'b0, sub, 4'($urandom)} : {sub, 5'($urandom)};
  endfunction

  task automatic run(input logic [1:0] op, input logic [6:0] a, input logic [15:0] dv,
                     input int dn);
    eeprom_host_model_i.shift(frame(op, a, dv, dn), (word ? 9 : 10) + dn, 0, rd);
  endtask

  task automatic special(input logic [1:0] sub, input logic [15:0] dv, input int dn);
    run(OP_SPECIAL, sub_addr(sub), dv, dn);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    eeprom_host_model_i.shift(frame(OP_READ, a, 16'h0000, 0), word ? 9 : 10,
                              word ? 17 : 9, rd);
    `CHECK(rd, word ? {1'b0, exp} : {9'h000, exp[7:0]})
  endtask

  task automatic wait_ready();
    eeprom_host_model_i.status(0, s, en_n);
    `CHECK({s, en_n}, 2'h0)
    eeprom_host_model_i.status(20, s, en_n);
    `CHECK({s, en_n}, 2'h2)
    if (s !== 1'b1) begin
      wrap_up();
    end
  endtask

  task automatic do_reset();
    i_resetn = 1'b0;
    eeprom_host_model_i.idle(3);
    repeat (5) @(posedge i_clock);
    #2 i_resetn = 1'b1;
    repeat (5000) @(posedge i_clock);
    `CHECK(o_serial_data_out_enable_n, 1'b1)
  endtask

  task automatic wrap_up();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    i_resetn = 1'b0;
    i_word_size_select = 1'b1;
    i_high_supply = 1'b0;
    word = 1'b1;
    d = 16'($urandom(32'h2DB1));
    w = 16'($urandom);
    a1 = 7'($urandom);
    a2 = a1 ^ 7'h15;
    do_reset();
    special(SUB_ENABLE, 16'h0000, 0);
    special(SUB_WRITE_ALL, w, 16);
    wait_ready();
    rd_chk(a1, w);
    rd_chk(a2, w);
    for (int k = 0; k < 4; k++) begin
      d = 16'($urandom);
      run(OP_WRITE, a1 + 7'(k), d, 16);
      wait_ready();
      rd_chk(a1 + 7'(k), d);
    end
    special(SUB_DISABLE, 16'h0000, 0);
    run(OP_WRITE, a1 + 7'h3, ~d, 16);
    rd_chk(a1 + 7'h3, d);
    special(SUB_ENABLE, 16'h0000, 0);
    run(OP_ERASE, a1, 16'h0000, 0);
    wait_ready();
    rd_chk(a1, ERASED_WORD);
    // first 20 of 25 bits: full header, data cut short by select falling
    eeprom_host_model_i.shift(frame(OP_WRITE, a2, ~w, 16) >> 5, 20, 0, rd);
    rd_chk(a2, w);
    special(SUB_ERASE_ALL, 16'h0000, 0);
    rd_chk(a2, w);
    @(posedge i_clock) #2 i_high_supply = 1'b1;
    special(SUB_ERASE_ALL, 16'h0000, 0);
    wait_ready();
    rd_chk(a2, ERASED_WORD);
    @(posedge i_clock) #2 i_word_size_select = 1'b0;
    word = 1'b0;
    eeprom_host_model_i.idle(3);
    b = 16'($urandom);
    run(OP_WRITE, {a1[5:0], 1'b1}, b, 8);
    wait_ready();
    rd_chk({a1[5:0], 1'b1}, b);
    rd_chk({a1[5:0], 1'b0}, ERASED_WORD);
    do_reset();
    run(OP_WRITE, {a1[5:0], 1'b1}, ~b, 8);
    rd_chk({a1[5:0], 1'b1}, b);
    wrap_up();
  end
endmodule
